/* src/rswt_map.svh */
/*
 * Offsets, reset values, selector codes and scaling figures of the receive-start wait timer.
 * Assumes it is included by its bare name wherever these names are used.
 */
`ifndef RSWT_MAP_SVH
`define RSWT_MAP_SVH

`define RSWT_ADDR_PHASE 6'h1B
`define RSWT_ADDR_WAIT 6'h21
`define RSWT_REG_RESET 8'h00
`define RSWT_RD_UNMAPPED 8'h00

`define RSWT_PERIOD_16 2'h1
`define RSWT_PERIOD_32 2'h2
`define RSWT_PERIOD_64 2'h3
`define RSWT_CLKS_16 7'h10
`define RSWT_CLKS_32 7'h20
`define RSWT_CLKS_64 7'h40

`define RSWT_PULSES_16 3'h4
`define RSWT_PULSES_32 3'h5
`define RSWT_PULSES_64 3'h6
`define RSWT_PULSES_MAX 3'h6
`define RSWT_N_1 4'h1
`define RSWT_N_2 4'h2
`define RSWT_N_4 4'h4
`define RSWT_N_8 4'h8

`define RSWT_CODE_MANCH 2'h0
`define RSWT_CODE_BPSK 2'h1
`define RSWT_FRAME_A 2'h1
`define RSWT_FRAME_VICINITY 2'h2
`define RSWT_FRAME_B 2'h3

`define RSWT_CNT_LAST 21'h000001
`define RSWT_CNT_ONE 21'h000001

`endif

/* src/rswt_pkg.sv */
/*
 * Types and clock arithmetic shared by the receive-start wait timer modules.
 * Assumes rswt_map.svh is on the include path.
 */
`include "rswt_map.svh"

package rswt_pkg;

    localparam int RSWT_TWAIT_WIDTH = 21;
    localparam int RSWT_ETU_WIDTH = 13;

    typedef logic [RSWT_TWAIT_WIDTH-1:0] rswt_twait_type;
    typedef logic [RSWT_ETU_WIDTH-1:0] rswt_etu_type;

    typedef enum logic [1:0] {
        RSWT_IDLE,
        RSWT_WAIT,
        RSWT_ACTIVE
    } rswt_state_type;

    // clocks per subcarrier pulse; the unused code 00 falls back to 16
    function automatic logic [6:0] rswt_period_clks(input logic [1:0] sel);
        logic [6:0] clks;
        case (sel)
            `RSWT_PERIOD_32: clks = `RSWT_CLKS_32;
            `RSWT_PERIOD_64: clks = `RSWT_CLKS_64;
            default: clks = `RSWT_CLKS_16;
        endcase
        return clks;
    endfunction : rswt_period_clks

    // pulses-per-bit exponent, with the unused code 111 clamped to 64 pulses
    function automatic logic [2:0] rswt_pulse_exp(input logic [2:0] sel);
        return (sel > `RSWT_PULSES_MAX) ? `RSWT_PULSES_MAX : sel;
    endfunction : rswt_pulse_exp

    function automatic rswt_etu_type rswt_etu_clks(input logic [1:0] periodSel, input logic [2:0] pulseSel);
        rswt_etu_type etu;
        etu = RSWT_ETU_WIDTH'(rswt_period_clks(periodSel)) << rswt_pulse_exp(pulseSel);
        return etu;
    endfunction : rswt_etu_clks

    function automatic logic [3:0] rswt_scale_n(input logic [2:0] pulseSel);
        logic [3:0] n;
        case (rswt_pulse_exp(pulseSel))
            `RSWT_PULSES_16: n = `RSWT_N_2;
            `RSWT_PULSES_32: n = `RSWT_N_4;
            `RSWT_PULSES_64: n = `RSWT_N_8;
            default: n = `RSWT_N_1;
        endcase
        return n;
    endfunction : rswt_scale_n

endpackage : rswt_pkg

/* src/rswt_wait_if.sv */
/*
 * Carrier between the wait timer control and its down-counter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps

interface rswt_wait_if
    import rswt_pkg::*;
();
    logic load;
    rswt_twait_type loadValue;
    logic expire;

    modport ctrl (output load, output loadValue, input expire);
    modport counter (input load, input loadValue, output expire);
endinterface : rswt_wait_if

/* src/rswt_wait_counter.sv */
/*
 * Down-counter that measures the wait interval in clock cycles.
 * Assumes load comes from the control in the same clock domain.
 */
`timescale 1ns/1ps

module rswt_wait_counter
    import rswt_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    rswt_wait_if.counter waitBus
);

    rswt_twait_type count;
    rswt_twait_type next_count;
    logic running;
    logic next_running;

    assign waitBus.expire = running && (count <= `RSWT_CNT_LAST);

    always_comb begin
        next_count = count;
        next_running = running;
        if (waitBus.load) begin
            // a new end of transmission restarts the measurement
            next_count = waitBus.loadValue;
            next_running = 1'h1;
        end else if (waitBus.expire) begin
            next_running = 1'h0;
        end else if (running) begin
            next_count = count - `RSWT_CNT_ONE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            count <= '0;
            running <= 1'h0;
        end else begin
            count <= next_count;
            running <= next_running;
        end
    end

endmodule : rswt_wait_counter

/* src/rswt_receive_start_wait_timer.sv */
/*
 * Receive-start wait timer: holds the wait and phase registers, computes the wait in clocks
 * from the subcarrier and pulses-per-bit selectors, raises receive start after it and gates
 * the analog receiver supply when automatic power-down is chosen.
 * Assumes a synchronous register port, one-cycle end-of-transmission and reception-done
 * strobes, and selector levels that stay steady during a transfer.
 * The wait settings are taken at the end-of-transmission edge; later changes to the
 * registers or selectors only affect the next wait.
 * The framing field is an input that nothing in the timer uses, and it does not shape the timing.
 */
`timescale 1ns/1ps

`include "rswt_map.svh"

// Behaviour
// - raise receive start after programmed wait
// - wait measured from last transmitted bit
// - wait equals etus times ETU plus phase times N
// - period selector gives 16, 32, 64 clocks
// - pulses-per-bit code k gives 2^k pulses, code 7 gives 64
// - N is 1, 2, 4 or 8
// - auto power-down: receiver on from end of transmission until reception done
// - correlator starts when receive start rises, except with the BPSK line code
module rswt_receive_start_wait_timer
    import rswt_pkg::*;
#(
    parameter int ADDR_WIDTH = 6,
    parameter int DATA_WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [ADDR_WIDTH-1:0] regAddr,
    input wire logic regWrite,
    input wire logic [DATA_WIDTH-1:0] regWrData,
    input wire logic regRead,
    output logic [DATA_WIDTH-1:0] regRdData,
    input wire logic txEnd,
    input wire logic rxDone,
    input wire logic [1:0] subcarrierPeriodSel,
    input wire logic [2:0] pulsesPerBitSel,
    input wire logic rxAutoPowerDown,
    input wire logic [1:0] rxFrameFormat,
    input wire logic [1:0] rxLineCode,
    output logic receiveStart,
    output logic correlatorStart,
    output logic rxPowerOn,
    output logic waitBusy
);

    rswt_wait_if waitBus ();

    rswt_wait_counter u_counter (
        .clk_sys(clk_sys),
        .reset(reset),
        .waitBus(waitBus)
    );

    // registers
    logic [DATA_WIDTH-1:0] rxPhaseFraction;
    logic [DATA_WIDTH-1:0] rxWaitEtus;
    logic [DATA_WIDTH-1:0] next_rxPhaseFraction;
    logic [DATA_WIDTH-1:0] next_rxWaitEtus;
    logic [DATA_WIDTH-1:0] next_regRdData;
    logic phaseWrite;
    logic waitWrite;

    // one address comparison shared by the write and read decoders
    function automatic logic regSelected(
        input logic [ADDR_WIDTH-1:0] addr,
        input logic [ADDR_WIDTH-1:0] target
    );
        return addr == target;
    endfunction : regSelected

    // read multiplexer; unmapped offsets read as a fixed value
    function automatic logic [DATA_WIDTH-1:0] regReadback(
        input logic [ADDR_WIDTH-1:0] addr,
        input logic [DATA_WIDTH-1:0] phase,
        input logic [DATA_WIDTH-1:0] etus
    );
        logic [DATA_WIDTH-1:0] value;
        if (regSelected(addr, ADDR_WIDTH'(`RSWT_ADDR_PHASE))) begin
            value = phase;
        end else if (regSelected(addr, ADDR_WIDTH'(`RSWT_ADDR_WAIT))) begin
            value = etus;
        end else begin
            value = DATA_WIDTH'(`RSWT_RD_UNMAPPED);
        end
        return value;
    endfunction : regReadback

    assign phaseWrite = regWrite && regSelected(regAddr, ADDR_WIDTH'(`RSWT_ADDR_PHASE));
    assign waitWrite = regWrite && regSelected(regAddr, ADDR_WIDTH'(`RSWT_ADDR_WAIT));

    always_comb begin
        next_rxPhaseFraction = rxPhaseFraction;
        next_rxWaitEtus = rxWaitEtus;
        next_regRdData = regRdData;
        if (phaseWrite) begin
            next_rxPhaseFraction = regWrData;
        end
        if (waitWrite) begin
            next_rxWaitEtus = regWrData;
        end
        // a read in the same cycle as a write returns the old value
        if (regRead) begin
            next_regRdData = regReadback(regAddr, rxPhaseFraction, rxWaitEtus);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rxPhaseFraction <= DATA_WIDTH'(`RSWT_REG_RESET);
            rxWaitEtus <= DATA_WIDTH'(`RSWT_REG_RESET);
            regRdData <= DATA_WIDTH'(`RSWT_REG_RESET);
        end else begin
            rxPhaseFraction <= next_rxPhaseFraction;
            rxWaitEtus <= next_rxWaitEtus;
            regRdData <= next_regRdData;
        end
    end

    // wait interval in clocks
    // widest case, 255 units of 4096 clocks plus 255 phase steps of 8, fits the wait width
    rswt_etu_type etuClks;
    logic [3:0] scaleN;
    rswt_twait_type etuPart;
    rswt_twait_type phasePart;
    rswt_twait_type twaitClks;

    always_comb begin
        etuClks = rswt_etu_clks(subcarrierPeriodSel, pulsesPerBitSel);
        scaleN = rswt_scale_n(pulsesPerBitSel);
        etuPart = RSWT_TWAIT_WIDTH'(rxWaitEtus) * RSWT_TWAIT_WIDTH'(etuClks);
        phasePart = RSWT_TWAIT_WIDTH'(rxPhaseFraction) * RSWT_TWAIT_WIDTH'(scaleN);
        twaitClks = etuPart + phasePart;
    end

    // control sequence
    rswt_state_type state;
    rswt_state_type next_state;
    logic next_receiveStart;
    logic next_correlatorStart;
    logic next_rxPowerOn;
    logic next_waitBusy;
    logic usesCorrelator;

    assign usesCorrelator = (rxLineCode != `RSWT_CODE_BPSK);

    // every end of transmission reloads the counter, so a retry restarts the wait
    assign waitBus.load = txEnd;
    assign waitBus.loadValue = twaitClks;

    always_comb begin
        next_state = state;
        case (state)
            RSWT_IDLE: begin
                if (txEnd) begin
                    next_state = RSWT_WAIT;
                end
            end
            RSWT_WAIT: begin
                if (txEnd) begin
                    next_state = RSWT_WAIT;
                end else if (waitBus.expire) begin
                    next_state = RSWT_ACTIVE;
                end
            end
            RSWT_ACTIVE: begin
                if (txEnd) begin
                    next_state = RSWT_WAIT;
                end else if (rxDone) begin
                    next_state = RSWT_IDLE;
                end
            end
            default: begin
                next_state = RSWT_IDLE;
            end
        endcase
        next_receiveStart = (next_state == RSWT_ACTIVE);
        next_waitBusy = (next_state == RSWT_WAIT);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= RSWT_IDLE;
            receiveStart <= 1'h0;
            waitBusy <= 1'h0;
        end else begin
            state <= next_state;
            receiveStart <= next_receiveStart;
            waitBusy <= next_waitBusy;
        end
    end

    // correlator kick: one cycle on the rise of receive start, none with the BPSK line code
    always_comb begin
        next_correlatorStart = usesCorrelator && (next_state == RSWT_ACTIVE) && (state != RSWT_ACTIVE);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            correlatorStart <= 1'h0;
        end else begin
            correlatorStart <= next_correlatorStart;
        end
    end

    // receiver supply
    always_comb begin
        // with auto power-down the receiver runs only from end of transmission to completion
        next_rxPowerOn = rxAutoPowerDown ? (next_state != RSWT_IDLE) : 1'h1;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rxPowerOn <= 1'h0;
        end else begin
            rxPowerOn <= next_rxPowerOn;
        end
    end

endmodule : rswt_receive_start_wait_timer

/* tb/rswt_timer_checker.sv */
/* Port checker for the receive-start wait timer.
   Assumes strobes and settings are sampled on the rising edge of clk_sys. */
`timescale 1ns/1ps

module rswt_timer_checker (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic txEnd,
    input wire logic rxDone,
    input wire logic rxAutoPowerDown,
    input wire logic [1:0] rxLineCode,
    input wire logic receiveStart,
    input wire logic correlatorStart,
    input wire logic rxPowerOn,
    input wire logic waitBusy
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    AST_RESTART: assert property (txEnd |=> !receiveStart)
        else $error("receive start held over a new transmission end");
    AST_HOLD: assert property (receiveStart && !txEnd |=> receiveStart != $past(rxDone))
        else $error("receive start not held until reception done");
    AST_AFTER_WAIT: assert property ($rose(receiveStart) |-> $past(waitBusy) || $past(txEnd, 2))
        else $error("receive start rose without a wait");
    AST_EXCLUSIVE: assert property (waitBusy |-> !receiveStart)
        else $error("busy and receive start together");
    AST_CORR_ONLY_ON_RISE: assert property (correlatorStart |-> $rose(receiveStart) && $past(rxLineCode) != 2'h1)
        else $error("correlator start off the rise");
    AST_CORR_ON_RISE: assert property ($rose(receiveStart) && $past(rxLineCode) != 2'h1 |-> correlatorStart)
        else $error("correlator start missing");
    AST_POWER_ALWAYS: assert property (!rxAutoPowerDown && !$past(rxAutoPowerDown) && !$past(reset) |-> rxPowerOn)
        else $error("receiver off without auto power-down");
    AST_POWER_AUTO: assert property (rxAutoPowerDown && $past(rxAutoPowerDown) && !$past(txEnd)
        |-> rxPowerOn == (waitBusy || receiveStart))
        else $error("receiver power not tracking reception");
endmodule : rswt_timer_checker

bind rswt_receive_start_wait_timer rswt_timer_checker checker_i (.clk_sys, .reset, .txEnd, .rxDone,
    .rxAutoPowerDown, .rxLineCode, .receiveStart, .correlatorStart, .rxPowerOn, .waitBusy);

/* tb/rswt_rx_decoder_model.sv */
/* Decoder stand-in: ends each reception lag cycles after receive start rises.
   Assumes the timer outputs change on the rising edge. */
`timescale 1ns/1ps

module rswt_rx_decoder_model (
    input wire logic clk_sys,
    input wire logic receiveStart,
    input wire logic [7:0] lag,
    output logic rxDone
);
    int count = 0;
    initial rxDone = 1'h0;
    // decoding only runs while receive start is up
    always @(posedge clk_sys) begin
        #1;
        rxDone = receiveStart === 1'h1 && count == int'(lag);
        count = (receiveStart === 1'h1 && !rxDone) ? count + 1 : 0;
    end
endmodule : rswt_rx_decoder_model

/* tb/rswt_testbench.sv */
/* Self-checking bench: register port, wait arithmetic per selector, restart, power-down.
   Assumes the decoder model closes every reception. */
`timescale 1ns/1ps

module testbench;
    logic clk_sys = 1'h0, reset = 1'h1, regWrite = 1'h0, regRead = 1'h0, txEnd = 1'h0, rxAutoPowerDown = 1'h0;
    logic [5:0] regAddr = 6'h00;
    logic [7:0] regWrData = 8'h00, regRdData, lag = 8'h00;
    logic [1:0] subcarrierPeriodSel = 2'h1, rxFrameFormat = 2'h1, rxLineCode = 2'h0;
    logic [2:0] pulsesPerBitSel = 3'h0;
    logic receiveStart, correlatorStart, rxPowerOn, waitBusy, rxDone;
    int miscompares = 0, comparisons = 0, cnt;

    always #2 clk_sys = ~clk_sys;

    rswt_receive_start_wait_timer dut (.clk_sys, .reset, .regAddr, .regWrite, .regWrData, .regRead,
        .regRdData, .txEnd, .rxDone, .subcarrierPeriodSel, .pulsesPerBitSel, .rxAutoPowerDown,
        .rxFrameFormat, .rxLineCode, .receiveStart, .correlatorStart, .rxPowerOn, .waitBusy);
    rswt_rx_decoder_model model (.clk_sys, .receiveStart, .lag, .rxDone);

    task check(input string what, input logic [20:0] seen, input logic [20:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task wr(input logic [5:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrite = 1'h1;
        @(posedge clk_sys) #1;
        regWrite = 1'h0;
        @(posedge clk_sys) #1;
    endtask : wr

    task rd(input logic [5:0] a, input logic [7:0] exp);
        regAddr = a;
        regRead = 1'h1;
        @(posedge clk_sys) #1;
        regRead = 1'h0;
        check("read data", regRdData, exp);
        @(posedge clk_sys) #1;
    endtask : rd

    task pulse;
        txEnd = 1'h1;
        @(posedge clk_sys) #1;
        txEnd = 1'h0;
    endtask : pulse

    task run(input logic [1:0] per, input logic [2:0] pul, input logic [7:0] etus, input logic [7:0] ph,
             input logic [1:0] code, input int pre);
        logic [20:0] etu, tgt, n;
        logic [2:0] k;
        k = (pul > 3'h6) ? 3'h6 : pul;
        etu = (per == 2'h3) ? 21'h40 : (per == 2'h2) ? 21'h20 : 21'h10;
        etu = etu << k;
        n = (k < 3'h4) ? 21'h1 : 21'h1 << (k - 3'h3);
        tgt = etus * etu + ph * n;
        tgt = (tgt == 21'h0) ? 21'h1 : tgt;
        wr(6'h21, etus);
        wr(6'h1B, ph);
        subcarrierPeriodSel = per;
        pulsesPerBitSel = pul;
        rxLineCode = code;
        pulse();
        if (pre > 0) begin
            repeat (pre) @(posedge clk_sys) #1;
            pulse();
        end
        cnt = 0;
        while (receiveStart !== 1'h1 && cnt < 9000) begin
            @(posedge clk_sys) #1;
            cnt++;
        end
        check("wait clocks", 21'(cnt), tgt);
        check("correlator start", correlatorStart, code != 2'h1);
        check("receiver power", rxPowerOn, 1'h1);
        cnt = 0;
        while (receiveStart === 1'h1 && cnt < 300) begin
            @(posedge clk_sys) #1;
            cnt++;
        end
        check("active clocks", 21'(cnt), 21'(lag) + 21'h1);
        check("receiver power", rxPowerOn, !rxAutoPowerDown);
    endtask : run

    task tally_and_finish;
        if (miscompares == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    initial begin
        #150000;
        miscompares++;
        tally_and_finish();
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        #1;
        reset = 1'h0;
        rd(6'h1B, 8'h00);
        rd(6'h21, 8'h00);
        wr(6'h21, 8'hA5);
        wr(6'h1B, 8'h5A);
        wr(6'h22, 8'hFF);
        rd(6'h21, 8'hA5);
        rd(6'h1B, 8'h5A);
        rd(6'h22, 8'h00);
        run(2'h1, 3'h4, 8'h02, 8'h03, 2'h0, 0);
        run(2'h2, 3'h1, 8'h01, 8'h05, 2'h1, 0);
        rxAutoPowerDown = 1'h1;
        lag = 8'h03;
        rxFrameFormat = 2'h3;
        run(2'h1, 3'h3, 8'h03, 8'h00, 2'h1, 0);
        run(2'h3, 3'h2, 8'h00, 8'h3D, 2'h0, 0);
        run(2'h1, 3'h5, 8'h01, 8'h01, 2'h1, 0);
        rxFrameFormat = 2'h2;
        lag = 8'h28;
        run(2'h2, 3'h6, 8'h02, 8'h0E, 2'h0, 0);
        run(2'h2, 3'h3, 8'h01, 8'h00, 2'h0, 30);
        run(2'h2, 3'h4, 8'h08, 8'h40, 2'h0, 0);
        rxAutoPowerDown = 1'h0;
        rxFrameFormat = 2'h1;
        run(2'h1, 3'h3, 8'h07, 8'h3D, 2'h0, 0);
        run(2'h1, 3'h3, 8'h03, 8'h88, 2'h0, 0);
        run(2'h1, 3'h0, 8'h03, 8'h00, 2'h1, 0);
        run(2'h0, 3'h7, 8'h01, 8'h01, 2'h2, 0);
        run(2'h2, 3'h4, 8'h00, 8'h00, 2'h0, 0);
        wr(6'h21, 8'h02);
        pulse();
        repeat (8) @(posedge clk_sys) #1;
        check("wait busy", waitBusy, 1'h1);
        reset = 1'h1;
        repeat (2) @(posedge clk_sys) #1;
        check("receiver power", rxPowerOn, 1'h0);
        check("wait busy", waitBusy, 1'h0);
        reset = 1'h0;
        cnt = 0;
        while (receiveStart !== 1'h1 && cnt < 1100) begin
            @(posedge clk_sys) #1;
            cnt++;
        end
        check("wait after reset", 21'(cnt), 21'h00044C);
        rd(6'h21, 8'h00);
        rd(6'h1B, 8'h00);
        tally_and_finish();
    end
endmodule : testbench
